/* File: sim/tb_top.sv */
`timescale 1ns/100ps
// ********
// bench
// ********
module tb_top;
   localparam int PER = 20000;
   logic aclk = 0, aresetn = 0, d0 = 0, sig;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb = 4'hf, adc_valid = 4'h0, chan_update, term_pullup_en, term_pulldown_en;
   logic [3:0] lim_low_fault, lim_high_fault;
   logic [3:0][15:0] adc_value = '0;
   logic [3:0][31:0] chan_value;
   // ch1 and ch2 share one sensor so both see identical edges
   wire [3:0] din = {1'b0, sig, sig, d0};
   int n_fail = 0, checks = 0;
   uic_top #(.SAMPLE_CYCLES(100)) dut_u (.ce(1'b1), .*);
   uic_sensor #(.PER(PER), .HI(PER / 2)) sen_u (.aclk(aclk), .sig(sig));
   initial forever #5 aclk = ~aclk;
   task automatic chk(input logic [31:0] s, e, input string n);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
      logic ta, tw;
      ta = 0;
      tw = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(ta && tw)) begin
         @(negedge aclk);
         ta |= s_axi_awready;
         tw |= s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      chk(32'(s_axi_bresp), 32'(r), "bresp");
      @(posedge aclk);
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, d, "rdata");
      chk(32'(s_axi_rresp), 32'(r), "rresp");
      @(posedge aclk);
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask
   task automatic an(input logic [15:0] v, input logic [31:0] e);
      adc_value[0] <= v;
      adc_valid[0] <= 1;
      @(posedge aclk);
      adc_valid[0] <= 0;
      do @(negedge aclk); while (chan_update[0] !== 1'b1);
      chk(chan_value[0], e, "value");
      @(posedge aclk);
   endtask
   task automatic t_regs;
      rd(32'h0, uic_pkg::CFG_RST, 2'h0);
      rd(32'h4, uic_pkg::DEB_RST, 2'h0);
      rd(32'h8, uic_pkg::LIM_RST, 2'h0);
      rd(32'h44, 32'h0, 2'h2);
      wr(32'hc, 32'h1, 2'h2);
      wr(32'h10, 32'h5, 2'h0);
      wr(32'h20, 32'h6, 2'h0);
      rd(32'h0, uic_pkg::CFG_RST, 2'h0);
   endtask
   task automatic t_volt;
      an(16'h1770, 32'(uic_pkg::VMAX_LO));
      wr(32'h0, 32'h11, 2'h0);
      an(16'h1770, 32'h1770);
      an(16'h2ee0, 32'(uic_pkg::VMAX_HI));
   endtask
   task automatic t_curr;
      wr(32'h0, 32'h22, 2'h0);
      chk(32'(lim_high_fault[0]), 32'h1, "hifault");
      an(16'h0bb7, 32'h0);
      an(uic_pkg::IOPEN, 32'(uic_pkg::IOPEN));
      wr(32'h0, 32'h2, 2'h0);
      an(16'h61a8, 32'(uic_pkg::IMAX));
      an(16'h0bb7, 32'h0bb7);
      wr(32'h0, 32'h4, 2'h0);
      an(16'h9c40, 32'h9c40);
   endtask
   task automatic t_disc;
      wr(32'h4, 32'h0, 2'h0);
      wr(32'h0, 32'h43, 2'h0);
      chk(32'(term_pullup_en), 32'h1, "pullup");
      d0 <= 1;
      repeat (250) @(posedge aclk);
      chk(chan_value[0], 32'h1, "level");
      wr(32'h0, 32'h143, 2'h0);
      repeat (250) @(posedge aclk);
      chk(chan_value[0], 32'h0, "inverted");
      wr(32'h4, 32'h3, 2'h0);
      d0 <= 0;
      repeat (250) @(posedge aclk);
      chk(chan_value[0], 32'h0, "deb held");
      repeat (250) @(posedge aclk);
      chk(chan_value[0], 32'h1, "deb done");
      wr(32'h0, 32'h81, 2'h0);
      chk(32'(term_pulldown_en), 32'h0, "pulldown");
   endtask
   task automatic t_freq;
      repeat (3) begin
         do @(negedge aclk); while (chan_update[1] !== 1'b1);
      end
      chk(chan_value[1], uic_pkg::BASE_HZ / (PER / uic_pkg::BASE_CYCLES), "hertz");
      chk(chan_value[2], uic_pkg::PCT / 2, "duty");
      @(posedge aclk);
      wr(32'h38, 32'h501, 2'h0);
      rd(32'h40, 32'h68, 2'h0);
   endtask
   initial begin
      repeat (95000) @(posedge aclk);
      n_fail++;
      final_report;
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_regs;
      t_volt;
      t_curr;
      t_disc;
      t_freq;
      final_report;
   end
endmodule // tb_top

/* File: sim/uic_chk.sv */
`timescale 1ns/100ps
// ********
// bus and pin checks
// ********
module uic_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [3:0][31:0] chan_value,
   input wire logic [3:0] term_pullup_en,
   input wire logic [3:0] term_pulldown_en
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   chk_wr_resp_due: assert property (wr_both |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   chk_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid repeated");
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while answering");
   chk_rd_resp_due: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read taken");
   chk_term_excl: assert property ((term_pullup_en & term_pulldown_en) == 4'h0)
      else $error("both resistors on");
   chk_rst_clear: assert property ($rose(aresetn) |-> chan_value == '0)
      else $error("value not cleared");
endmodule // uic_chk
bind uic_top uic_chk chk_u (.*);

/* File: sim/uic_sensor.sv */
`timescale 1ns/100ps
// ********
// sensor model
// ********
module uic_sensor #(
   parameter int PER = 20000,
   parameter int HI = 10000
) (
   input wire logic aclk,
   output logic sig
);
   int cnt = 0;
   always_ff @(posedge aclk) begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      sig <= cnt < HI;
   end
endmodule // uic_sensor

/* File: src/uic_edge.sv */
`timescale 1ns/100ps
module uic_edge (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic enable,
   input wire logic pin,
   input wire logic pol,
   input wire logic pwm,
   input wire logic [1:0] glitch,
   input wire logic [1:0] avg,
   input wire logic base_tick,
   output logic [31:0] result,
   output logic result_valid
);
   logic [9:0] gcnt;
   logic [9:0] glim;
   logic stable;
   logic act_q;
   logic armed;
   logic [15:0] per_cnt;
   logic [15:0] hi_cnt;
   logic [15:0] per_hist [uic_pkg::HIST_LEN];
   logic [15:0] hi_hist [uic_pkg::HIST_LEN];
   logic [3:0] nread;
   logic [3:0] nfill;
   logic [31:0] psum;
   logic [31:0] hsum;
   logic [31:0] quo;
   logic [31:0] rem;
   logic [31:0] den;
   logic [5:0] step;
   logic busy;
   logic active;
   logic rise;
   logic fresh;

   // ****************************************
   // glitch filter
   // ****************************************
   always_comb begin
      unique case (glitch)
         2'h0: glim = 10'h000;
         2'h1: glim = 10'(uic_pkg::GLITCH1_CYC);
         2'h2: glim = 10'(uic_pkg::GLITCH2_CYC);
         2'h3: glim = 10'(uic_pkg::GLITCH3_CYC);
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stable <= 1'b0;
         gcnt <= 10'h000;
      end else if (ce) begin
         if (pin == stable) begin
            gcnt <= 10'h000;
         end else if (gcnt + 10'h001 >= glim) begin
            stable <= pin;
            gcnt <= 10'h000;
         end else begin
            gcnt <= gcnt + 10'h001;
         end
      end
   end

   assign active = stable ^ pol;
   assign rise = active && !act_q;

   // ****************************************
   // period counting
   // ****************************************
   // 16-bit tick counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q <= 1'b0;
         fresh <= 1'b0;
         armed <= 1'b0;
         per_cnt <= 16'h0000;
         hi_cnt <= 16'h0000;
         nfill <= 4'h0;
      end else if (ce) begin
         act_q <= active;
         // one divider start per new reading, not per idle cycle
         fresh <= enable && rise && armed;
         if (!enable || per_cnt == 16'hffff) begin
            // below the range: start over, reading reports zero
            armed <= 1'b0;
            nfill <= 4'h0;
            per_cnt <= 16'h0000;
            hi_cnt <= 16'h0000;
         end else if (rise) begin
            armed <= 1'b1;
            per_cnt <= 16'h0000;
            hi_cnt <= 16'h0000;
            if (armed && nfill != 4'(uic_pkg::HIST_LEN)) begin
               nfill <= nfill + 4'h1;
            end
         end else if (base_tick && armed) begin
            per_cnt <= per_cnt + 16'h0001;
            if (active) begin
               hi_cnt <= hi_cnt + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (ce && enable && rise && armed) begin
         per_hist[0] <= per_cnt;
         hi_hist[0] <= hi_cnt;
         for (int i = 1; i < uic_pkg::HIST_LEN; i++) begin
            per_hist[i] <= per_hist[i - 1];
            hi_hist[i] <= hi_hist[i - 1];
         end
      end
   end

   // ****************************************
   // moving average
   // ****************************************
   // average over 1, 3, 5, 10
   always_comb begin
      unique case (avg)
         2'h0: nread = 4'h1;
         2'h1: nread = 4'h3;
         2'h2: nread = 4'h5;
         2'h3: nread = 4'ha;
      endcase
      psum = 32'h0000_0000;
      hsum = 32'h0000_0000;
      for (int i = 0; i < uic_pkg::HIST_LEN; i++) begin
         if (4'(i) < nread && 4'(i) < nfill) begin
            psum = psum + {16'h0000, per_hist[i]};
            hsum = hsum + {16'h0000, hi_hist[i]};
         end
      end
   end

   // ****************************************
   // divider: Hz = base*n/sum, % = 100*high/period
   // ****************************************
   // one restoring divider per channel, 32 cycles a reading
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy <= 1'b0;
         step <= 6'h00;
         quo <= 32'h0000_0000;
         rem <= 32'h0000_0000;
         den <= 32'h0000_0001;
         result <= 32'h0000_0000;
         result_valid <= 1'b0;
      end else if (ce) begin
         result_valid <= 1'b0;
         if (!enable || !armed) begin
            busy <= 1'b0;
            result <= 32'h0000_0000;
         end else if (!busy && fresh && psum != 32'h0000_0000) begin
            busy <= 1'b1;
            step <= 6'h00;
            rem <= 32'h0000_0000;
            den <= psum;
            if (pwm) begin
               quo <= 32'(hsum * uic_pkg::PCT);
            end else begin
               quo <= 32'(uic_pkg::BASE_HZ * {28'h0000000, (nfill < nread) ? nfill : nread});
            end
         end else if (busy) begin
            if ({rem[30:0], quo[31]} >= den) begin
               rem <= {rem[30:0], quo[31]} - den;
               quo <= {quo[30:0], 1'b1};
            end else begin
               rem <= {rem[30:0], quo[31]};
               quo <= {quo[30:0], 1'b0};
            end
            step <= step + 6'h01;
            if (step == 6'h1f) begin
               busy <= 1'b0;
               result_valid <= 1'b1;
               result <= {quo[30:0], ({rem[30:0], quo[31]} >= den)};
            end
         end
      end
   end
endmodule // uic_edge

/* File: src/uic_pkg.sv */
package uic_pkg;
   // ****************************************
   // channel count and clock
   // ****************************************
   localparam int NUM_CH = 4;
   localparam int CLK_PERIOD_NS = 10;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] CH_STRIDE = 8'h10;
   localparam logic [3:0] CFG_OFS = 4'h0;
   localparam logic [3:0] DEB_OFS = 4'h4;
   localparam logic [3:0] LIM_OFS = 4'h8;
   localparam logic [3:0] VAL_OFS = 4'hc;
   localparam logic [7:0] STAT_OFS = 8'h40;

   // cfg word fields
   localparam int MODE_POS = 0;
   localparam int VRANGE_POS = 4;
   localparam int IRANGE_POS = 5;
   localparam int TERM_POS = 6;
   localparam int POL_POS = 8;
   localparam int GLITCH_POS = 9;
   localparam int AVG_POS = 11;
   localparam logic [31:0] CFG_MASK = 32'h0000_1ff7;
   // deb word: ms in [9:0]; lim word: low [6:0], high [14:8]
   localparam int LIM_HI_POS = 8;
   localparam logic [31:0] DEB_MASK = 32'h0000_03ff;
   localparam logic [31:0] LIM_MASK = 32'h0000_7f7f;

   // reset values: voltage mode, debounce 50 ms, high limit 5, everything else zero
   localparam logic [31:0] CFG_RST = 32'h0000_0001;
   localparam logic [31:0] DEB_RST = 32'h0000_0032;
   localparam logic [31:0] LIM_RST = 32'h0000_0500;

   // ****************************************
   // enumerations
   // ****************************************
   typedef enum logic [2:0] {
      UIC_OFF = 3'h0, UIC_VOLT = 3'h1, UIC_CURR = 3'h2, UIC_DISC = 3'h3,
      UIC_RES = 3'h4, UIC_FREQ = 3'h5, UIC_PWM = 3'h6
   } uic_mode_type;

   typedef enum logic [1:0] {
      UIC_TERM_NONE = 2'h0, UIC_TERM_UP = 2'h1, UIC_TERM_DOWN = 2'h2
   } uic_term_type;

   typedef struct packed {
      logic [6:0] lim_hi;
      logic [6:0] lim_lo;
      logic [9:0] deb_ms;
      logic [1:0] avg;
      logic [1:0] glitch;
      logic pol;
      logic [1:0] term;
      logic irange;
      logic vrange;
      logic [2:0] mode;
   } uic_cfg_type;

   // ****************************************
   // scaling, values in mV, uA, ohm, Hz, %
   // ****************************************
   localparam logic [15:0] VMAX_LO = 16'h1388;
   localparam logic [15:0] VMAX_HI = 16'h2710;
   localparam logic [15:0] IMAX = 16'h4e20;
   localparam logic [15:0] IOPEN = 16'h0bb8;
   localparam logic [31:0] MILLI = 32'h0000_03e8;
   localparam logic [31:0] PCT = 32'h0000_0064;

   // ****************************************
   // timing
   // ****************************************
   localparam int SAMPLE_PERIOD_NS = 1000000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int GLITCH1_NS = 142;
   localparam int GLITCH2_NS = 1140;
   localparam int GLITCH3_NS = 6100;
   localparam int GLITCH1_CYC = (GLITCH1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GLITCH2_CYC = (GLITCH2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GLITCH3_CYC = (GLITCH3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BASE_PERIOD_NS = 20000;
   localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [31:0] BASE_HZ = 32'd1000000000 / BASE_PERIOD_NS;
   localparam int HIST_LEN = 10;
endpackage

/* File: src/uic_top.sv */
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Functional notes
// - four identical channels, each with its own output value.
// - mode code 0 off, 1 volt, 2 current, 3 discrete, 4 ohm, 5 Hz, 6 PWM.
// - output in mV, uA, ohm, Hz or percent; discrete gives 0 or 1.
// - voltage span 0-5 V (code 0, default) or 0-10 V (code 1).
// - current span 0-20 mA (code 0, default) or 4-20 mA (code 1).
// - in 4-20 mA span, current under 3 mA reads as zero.
// - low and high limits 0..127, defaults 0 and 5, diagnostics only.
// - termination none, pull-up, pull-down; only in discrete, Hz, PWM modes.
// - frequency and PWM count 16-bit base ticks per input period.
// - moving average of 1, 3, 5 or 10 readings in Hz/PWM modes.
// - discrete level sampled each millisecond; debounce up to 1023 ms.
// - debounce of zero passes samples straight through.
// - polarity selects active level/edge for discrete, Hz and PWM.
module uic_top #(
   parameter int SAMPLE_CYCLES = uic_pkg::SAMPLE_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] din,
   input wire logic [3:0][15:0] adc_value,
   input wire logic [3:0] adc_valid,
   output logic [3:0][31:0] chan_value,
   output logic [3:0] chan_update,
   output logic [3:0] term_pullup_en,
   output logic [3:0] term_pulldown_en,
   output logic [3:0] lim_low_fault,
   output logic [3:0] lim_high_fault
);
   logic [31:0] cfg_reg [uic_pkg::NUM_CH];
   logic [31:0] deb_reg [uic_pkg::NUM_CH];
   logic [31:0] lim_reg [uic_pkg::NUM_CH];
   logic aw_hold;
   logic w_hold;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic [31:0] next_rdata;
   logic [16:0] samp_cnt;
   logic samp_tick;
   logic [10:0] base_cnt;
   logic base_tick;

   // ****************************************
   // address decoding
   // ****************************************
   function automatic logic addr_ok(input logic [31:0] a);
      return (a[31:8] == 24'h000000) && (a[1:0] == 2'b00) && (a[7:0] <= uic_pkg::STAT_OFS);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r & mask;
   endfunction

   // ****************************************
   // axi4-lite write path
   // ****************************************
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign do_write = aw_hold && w_hold && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         awaddr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_hold <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_hold <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (ce) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            // unmapped or read-only targets answer slverr
            s_axi_bresp <= (addr_ok(awaddr_q) && awaddr_q[7:0] != uic_pkg::STAT_OFS
                            && awaddr_q[3:0] != uic_pkg::VAL_OFS) ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int c = 0; c < uic_pkg::NUM_CH; c++) begin
            cfg_reg[c] <= uic_pkg::CFG_RST;
            deb_reg[c] <= uic_pkg::DEB_RST;
            lim_reg[c] <= uic_pkg::LIM_RST;
         end
      end else if (ce && do_write && addr_ok(awaddr_q) && awaddr_q[7:0] < uic_pkg::STAT_OFS) begin
         unique case (awaddr_q[3:0])
            uic_pkg::CFG_OFS: cfg_reg[awaddr_q[5:4]] <= merge(cfg_reg[awaddr_q[5:4]], wdata_q, wstrb_q,
                                                              uic_pkg::CFG_MASK);
            uic_pkg::DEB_OFS: deb_reg[awaddr_q[5:4]] <= merge(deb_reg[awaddr_q[5:4]], wdata_q, wstrb_q,
                                                              uic_pkg::DEB_MASK);
            uic_pkg::LIM_OFS: lim_reg[awaddr_q[5:4]] <= merge(lim_reg[awaddr_q[5:4]], wdata_q, wstrb_q,
                                                              uic_pkg::LIM_MASK);
            default: ;
         endcase
      end
   end

   // ****************************************
   // axi4-lite read path
   // ****************************************
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr[7:0] == uic_pkg::STAT_OFS) begin
         next_rdata = {24'h000000, lim_high_fault, lim_low_fault};
      end else begin
         unique case (s_axi_araddr[3:0])
            uic_pkg::CFG_OFS: next_rdata = cfg_reg[s_axi_araddr[5:4]];
            uic_pkg::DEB_OFS: next_rdata = deb_reg[s_axi_araddr[5:4]];
            uic_pkg::LIM_OFS: next_rdata = lim_reg[s_axi_araddr[5:4]];
            uic_pkg::VAL_OFS: next_rdata = chan_value[s_axi_araddr[5:4]];
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= addr_ok(s_axi_araddr) ? next_rdata : 32'h0000_0000;
            s_axi_rresp <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // shared timebases
   // ****************************************
   // one millisecond sample tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samp_cnt <= 17'h00000;
      end else if (ce) begin
         samp_cnt <= samp_tick ? 17'h00000 : samp_cnt + 17'h00001;
      end
   end
   assign samp_tick = (samp_cnt == 17'(SAMPLE_CYCLES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_cnt <= 11'h000;
      end else if (ce) begin
         base_cnt <= base_tick ? 11'h000 : base_cnt + 11'h001;
      end
   end
   assign base_tick = (base_cnt == 11'(uic_pkg::BASE_CYCLES - 1));

   // ****************************************
   // channels
   // ****************************************
   // four independent channels
   for (genvar ch = 0; ch < uic_pkg::NUM_CH; ch++) begin : g_ch
      uic_pkg::uic_cfg_type cfg;
      logic [31:0] edge_result;
      logic edge_valid;
      logic samp;
      logic disc;
      logic [9:0] dcnt;
      logic [15:0] vmax;
      logic [31:0] scale;
      logic digital_mode;
      logic edge_mode;

      assign cfg = '{lim_hi: lim_reg[ch][uic_pkg::LIM_HI_POS +: 7], lim_lo: lim_reg[ch][6:0],
                     deb_ms: deb_reg[ch][9:0], avg: cfg_reg[ch][uic_pkg::AVG_POS +: 2],
                     glitch: cfg_reg[ch][uic_pkg::GLITCH_POS +: 2], pol: cfg_reg[ch][uic_pkg::POL_POS],
                     term: cfg_reg[ch][uic_pkg::TERM_POS +: 2], irange: cfg_reg[ch][uic_pkg::IRANGE_POS],
                     vrange: cfg_reg[ch][uic_pkg::VRANGE_POS], mode: cfg_reg[ch][uic_pkg::MODE_POS +: 3]};
      assign edge_mode = (cfg.mode == uic_pkg::UIC_FREQ) || (cfg.mode == uic_pkg::UIC_PWM);
      assign digital_mode = edge_mode || (cfg.mode == uic_pkg::UIC_DISC);

      assign term_pullup_en[ch] = digital_mode && cfg.term == uic_pkg::UIC_TERM_UP;
      assign term_pulldown_en[ch] = digital_mode && cfg.term == uic_pkg::UIC_TERM_DOWN;

      uic_edge u_edge (
         .aclk(aclk),
         .aresetn(aresetn),
         .ce(ce),
         .enable(edge_mode),
         .pin(din[ch]),
         .pol(cfg.pol),
         .pwm(cfg.mode == uic_pkg::UIC_PWM),
         .glitch(cfg.glitch),
         .avg(cfg.avg),
         .base_tick(base_tick),
         .result(edge_result),
         .result_valid(edge_valid)
      );

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            samp <= 1'b0;
            disc <= 1'b0;
            dcnt <= 10'h000;
         end else if (ce && samp_tick) begin
            samp <= din[ch] ^ cfg.pol;
            if (cfg.deb_ms == 10'h000) begin
               disc <= samp;
               dcnt <= 10'h000;
            end else if (samp == disc) begin
               dcnt <= 10'h000;
            end else if (dcnt + 10'h001 >= cfg.deb_ms) begin
               disc <= samp;
               dcnt <= 10'h000;
            end else begin
               dcnt <= dcnt + 10'h001;
            end
         end
      end

      assign vmax = cfg.vrange ? uic_pkg::VMAX_HI : uic_pkg::VMAX_LO;

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            chan_value[ch] <= 32'h0000_0000;
            chan_update[ch] <= 1'b0;
         end else if (ce) begin
            chan_update[ch] <= 1'b0;
            unique case (cfg.mode)
               uic_pkg::UIC_VOLT: begin
                  if (adc_valid[ch]) begin
                     chan_value[ch] <= {16'h0000, (adc_value[ch] > vmax) ? vmax : adc_value[ch]};
                     chan_update[ch] <= 1'b1;
                  end
               end
               uic_pkg::UIC_CURR: begin
                  if (adc_valid[ch]) begin
                     if (cfg.irange && adc_value[ch] < uic_pkg::IOPEN) begin
                        chan_value[ch] <= 32'h0000_0000;
                     end else begin
                        chan_value[ch] <= {16'h0000, (adc_value[ch] > uic_pkg::IMAX) ? uic_pkg::IMAX
                                                                                      : adc_value[ch]};
                     end
                     chan_update[ch] <= 1'b1;
                  end
               end
               uic_pkg::UIC_RES: begin
                  if (adc_valid[ch]) begin
                     chan_value[ch] <= {16'h0000, adc_value[ch]};
                     chan_update[ch] <= 1'b1;
                  end
               end
               uic_pkg::UIC_DISC: begin
                  chan_value[ch] <= {31'h0000_0000, disc};
                  chan_update[ch] <= samp_tick;
               end
               uic_pkg::UIC_FREQ, uic_pkg::UIC_PWM: begin
                  chan_value[ch] <= edge_result;
                  chan_update[ch] <= edge_valid;
               end
               default: begin
                  chan_value[ch] <= 32'h0000_0000;
               end
            endcase
         end
      end

      assign scale = (cfg.mode == uic_pkg::UIC_VOLT || cfg.mode == uic_pkg::UIC_CURR) ? uic_pkg::MILLI
                                                                                       : 32'h0000_0001;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            lim_low_fault[ch] <= 1'b0;
            lim_high_fault[ch] <= 1'b0;
         end else if (ce) begin
            // discrete and off have no meaningful range
            if (cfg.mode == uic_pkg::UIC_OFF || cfg.mode == uic_pkg::UIC_DISC) begin
               lim_low_fault[ch] <= 1'b0;
               lim_high_fault[ch] <= 1'b0;
            end else begin
               lim_low_fault[ch] <= chan_value[ch] < 32'({25'h0, cfg.lim_lo} * scale);
               lim_high_fault[ch] <= chan_value[ch] > 32'({25'h0, cfg.lim_hi} * scale);
            end
         end
      end
   end
endmodule // uic_top
